//--- inc/bimec_pkg.sv
package bimec_pkg;
  // register offsets (byte addresses)
  localparam int ADDR_W = 12;
  localparam logic [11:0] OFF_MODE = 12'hC00;
  localparam logic [11:0] OFF_MERR = 12'hC40;
  localparam logic [11:0] OFF_IRQ_MASK = 12'hC44;
  localparam logic [11:0] OFF_BERR = 12'hC48;
  localparam logic [11:0] OFF_CMD_LATCH = 12'hC4C;
  localparam logic [11:0] OFF_SYN_LATCH = 12'hC50;
  localparam logic [11:0] OFF_FILL_ADDR = 12'hC54;
  localparam logic [11:0] OFF_IF_STATUS = 12'hC58;
  // mode register fields
  localparam int MODE_LOCK_IN = 14;
  localparam int MODE_LOCK_MODE = 7;
  localparam int MODE_LOCK_ALL = 6;
  localparam int MODE_PCO_LO = 4;
  localparam int MODE_SWP_LO = 2;
  localparam int MODE_BCS_LO = 0;
  localparam logic [31:0] MODE_WMASK = 32'h0000_40FF;
  localparam logic [31:0] MODE_RESET = 32'h0000_0000;
  // error flag positions
  localparam int MERR_W = 11;
  localparam int ERR_ARB_DROP = 10;
  localparam int ERR_ARB_COL = 9;
  localparam int ERR_DATA_DBE = 8;
  localparam int ERR_DATA_SBE = 7;
  localparam int ERR_MAP_PE = 6;
  localparam int ERR_STAT_PE = 5;
  localparam int ERR_TAG_PE = 4;
  localparam int ERR_PMAP_LO = 0;
  localparam int BERR_NSUM = 18;
  localparam logic [MERR_W-1:0] MERR_RESET = 11'h000;
  // snoop write policy codes
  localparam logic [1:0] SWP_LOOKUP = 2'h0;
  localparam logic [1:0] SWP_INVAL = 2'h1;
  localparam logic [1:0] SWP_UPDATE = 2'h2;
  // backup cache size codes
  localparam logic [1:0] BCS_4M = 2'h0;
  localparam logic [1:0] BCS_1M = 2'h1;
  localparam logic [1:0] BCS_16M = 2'h2;
endpackage

//--- logic/bimec_regs.sv
`timescale 1ns/1ps
module bimec_regs #(
  parameter int ADDR_BITS = 34, // bus address width
  parameter int CMD_BITS = 4,   // bus command width
  parameter int SYN_BITS = 8    // ecc syndrome width
) (
  input wire logic i_clk_sys, // system clock
  input wire logic i_reset_n, // async reset, active low
  input wire logic [bimec_pkg::ADDR_W-1:0] i_reg_addr, // register byte address
  input wire logic [31:0] i_reg_wdata, // write data
  input wire logic i_reg_wr, // write strobe
  input wire logic i_reg_rd, // read strobe
  output logic [31:0] o_reg_rdata, // read data, cycle after strobe
  input wire logic i_lockout_pin, // bus lockout seen on backplane
  output logic o_lockout_drive, // drive bus lockout
  input wire logic i_own_req, // own transaction request
  input wire logic i_own_wb_kind, // request is secondary or victim write
  output logic o_own_grant_ok, // own request allowed to arbitrate
  input wire logic i_snoop_write, // snooped bus write
  input wire logic i_pmap_hit, // primary-map lookup says update
  output logic o_snoop_inval, // invalidate backup cache
  output logic o_snoop_update, // update backup cache
  output logic [1:0] o_cache_size, // backup cache size code
  output logic [1:0] o_pcache_org, // processor cache organisation
  input wire logic i_crd, // correctable read indication
  input wire logic i_arb_drop, // arbitration won, no command
  input wire logic i_arb_col, // arbitration in illegal slot
  input wire logic i_data_dbe, // double ecc error on unload
  input wire logic i_data_sbe, // single ecc error on unload
  input wire logic i_map_pe, // map ram parity error
  input wire logic i_stat_pe, // status ram parity error
  input wire logic i_tag_pe, // tag ram parity error
  input wire logic i_probe_miss, // probe came from processor miss
  input wire logic [3:0] i_pmap_pe, // primary-map ram parity errors
  input wire logic [CMD_BITS-1:0] i_err_cmd, // bus command at error
  input wire logic [ADDR_BITS-1:0] i_err_addr, // address at error
  input wire logic [SYN_BITS-1:0] i_err_syn, // ecc syndrome at error
  output logic o_node_err_sum, // node error summary
  output logic o_irq // interrupt, level
);
  import bimec_pkg::*;

  // elaboration check: latch widths the read port can serve
  // the command/address latch may be wider than 32 bits; only its low word is readable
  if (ADDR_BITS < 1 || CMD_BITS < 1 || SYN_BITS < 1 || SYN_BITS > 32) begin : g_bad_widths
    $error("bimec_regs: latch widths out of range");
  end

  logic [31:0] mode_q;
  logic [MERR_W-1:0] merr_q;
  logic [MERR_W-1:0] merr_d;
  logic [MERR_W-1:0] mask_q;
  logic [MERR_W-1:0] ev;
  logic [CMD_BITS+ADDR_BITS-1:0] cmd_latch_q;
  logic [SYN_BITS-1:0] syn_latch_q;
  logic [ADDR_BITS-1:0] fill_addr_q;
  logic if_stat_q;
  logic [1:0] lock_sync_q;
  logic [1:0] crd_sync_q;
  logic wr_mode;
  logic wr_merr;
  logic bus_probe_pe;
  logic miss_probe_pe;
  logic latch_cmd;

  // strobes per register
  assign wr_mode = i_reg_wr && (i_reg_addr == OFF_MODE);
  assign wr_merr = i_reg_wr && (i_reg_addr == OFF_MERR);

  // pin inputs through two flip-flops
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      lock_sync_q <= 2'h0;
      crd_sync_q <= 2'h0;
    end else begin
      lock_sync_q <= {lock_sync_q[0], i_lockout_pin};
      crd_sync_q <= {crd_sync_q[0], i_crd};
    end
  end

  // mode register; lock-mode bit stored but drives nothing
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      mode_q <= MODE_RESET;
    end else if (wr_mode) begin
      mode_q <= i_reg_wdata & MODE_WMASK;
    end
  end

  // events gathered into flag layout
  always_comb begin
    bus_probe_pe = (i_stat_pe || i_tag_pe) && !i_probe_miss;
    miss_probe_pe = (i_stat_pe || i_tag_pe) && i_probe_miss;
    ev = '0;
    ev[ERR_ARB_DROP] = i_arb_drop;
    ev[ERR_ARB_COL] = i_arb_col;
    ev[ERR_DATA_DBE] = i_data_dbe;
    ev[ERR_DATA_SBE] = i_data_sbe;
    ev[ERR_MAP_PE] = i_map_pe;
    ev[ERR_STAT_PE] = i_stat_pe;
    ev[ERR_TAG_PE] = i_tag_pe;
    ev[ERR_PMAP_LO +: 4] = i_pmap_pe;
    latch_cmd = i_arb_drop || i_data_dbe || i_data_sbe || i_map_pe || bus_probe_pe || (|i_pmap_pe);
  end

  // sticky flags, set wins over write-one clear
  always_comb begin
    merr_d = merr_q;
    if (wr_merr) begin
      merr_d = merr_q & ~i_reg_wdata[MERR_W-1:0];
    end
    merr_d = merr_d | ev;
  end

  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      merr_q <= MERR_RESET;
    end else begin
      merr_q <= merr_d;
    end
  end

  // interrupt mask
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      mask_q <= MERR_RESET;
    end else if (i_reg_wr && i_reg_addr == OFF_IRQ_MASK) begin
      mask_q <= i_reg_wdata[MERR_W-1:0];
    end
  end

  // command/address and syndrome latches
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      cmd_latch_q <= '0;
      syn_latch_q <= '0;
    end else begin
      if (latch_cmd) begin
        cmd_latch_q <= {i_err_cmd, i_err_addr};
      end
      if (i_data_dbe || i_data_sbe) begin
        syn_latch_q <= i_err_syn;
      end
    end
  end

  // processor-miss probe errors: status bit and fill address
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      if_stat_q <= 1'b0;
      fill_addr_q <= '0;
    end else if (miss_probe_pe) begin
      if_stat_q <= 1'b1;
      fill_addr_q <= i_err_addr;
    end else if (i_reg_wr && i_reg_addr == OFF_IF_STATUS && i_reg_wdata[0]) begin
      if_stat_q <= 1'b0;
    end
  end

  // lock, snoop and configuration outputs
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_lockout_drive <= 1'b0;
      o_own_grant_ok <= 1'b0;
      o_snoop_inval <= 1'b0;
      o_snoop_update <= 1'b0;
      o_cache_size <= 2'h0;
      o_pcache_org <= 2'h0;
      o_node_err_sum <= 1'b0;
      o_irq <= 1'b0;
    end else begin
      o_lockout_drive <= mode_q[MODE_LOCK_IN] && crd_sync_q[1];
      o_own_grant_ok <= i_own_req && (!(mode_q[MODE_LOCK_ALL] && lock_sync_q[1]) || i_own_wb_kind);
      unique case (mode_q[MODE_SWP_LO +: 2])
        SWP_LOOKUP: begin
          o_snoop_inval <= i_snoop_write && !i_pmap_hit;
          o_snoop_update <= i_snoop_write && i_pmap_hit;
        end
        SWP_INVAL: begin
          o_snoop_inval <= i_snoop_write;
          o_snoop_update <= 1'b0;
        end
        SWP_UPDATE: begin
          o_snoop_inval <= 1'b0;
          o_snoop_update <= i_snoop_write;
        end
        default: begin
          o_snoop_inval <= 1'b0;
          o_snoop_update <= 1'b0;
        end
      endcase
      o_cache_size <= mode_q[MODE_BCS_LO +: 2];
      o_pcache_org <= mode_q[MODE_PCO_LO +: 2];
      o_node_err_sum <= |merr_d;
      o_irq <= |(merr_d & mask_q);
    end
  end

  // read port, data the cycle after the strobe
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_reg_rdata <= 32'h0000_0000;
    end else if (i_reg_rd) begin
      unique case (i_reg_addr)
        OFF_MODE: o_reg_rdata <= mode_q;
        OFF_MERR: o_reg_rdata <= {21'h000000, merr_q};
        OFF_IRQ_MASK: o_reg_rdata <= {21'h000000, mask_q};
        OFF_BERR: o_reg_rdata <= 32'(|merr_q) << BERR_NSUM;
        OFF_CMD_LATCH: o_reg_rdata <= 32'(cmd_latch_q);
        OFF_SYN_LATCH: o_reg_rdata <= 32'(syn_latch_q);
        OFF_FILL_ADDR: o_reg_rdata <= 32'(fill_addr_q);
        OFF_IF_STATUS: o_reg_rdata <= {31'h00000000, if_stat_q};
        default: o_reg_rdata <= 32'h0000_0000;
      endcase
    end else begin
      o_reg_rdata <= 32'h0000_0000;
    end
  end
endmodule

//--- verification/bimec_node_model.sv
`timescale 1ns/1ps
// far-side bus node and cache rams: error events, lockout, correctable reads
module bimec_node_model (
  input wire logic i_clk_sys, // clock
  output logic [10:0] o_evt, // one bit per error flag
  output logic o_miss, // probe from a processor miss
  output logic [3:0] o_cmd, // command at error
  output logic [33:0] o_addr, // address at error
  output logic [7:0] o_syn, // syndrome at error
  output logic o_lockout, // lockout from another node
  output logic o_crd // correctable read seen
);
  initial begin
    {o_evt, o_miss, o_cmd, o_addr, o_syn, o_lockout, o_crd} = '0;
  end
  // one-cycle event; command, address and syndrome turn to their inverse once it is over, miss holds
  task automatic fire(input int idx, input logic miss);
    @(posedge i_clk_sys);
    o_evt <= 11'h001 << idx;
    o_miss <= miss;
    o_cmd <= 4'(idx);
    o_addr <= 34'h100 + 34'(idx);
    o_syn <= 8'(idx);
    @(posedge i_clk_sys);
    o_evt <= 11'h000;
    {o_cmd, o_addr, o_syn} <= ~{o_cmd, o_addr, o_syn};
  endtask
  // lockout and correctable read, changed after an edge
  task automatic lock(input logic lo, input logic c);
    @(posedge i_clk_sys);
    o_lockout <= lo;
    o_crd <= c;
  endtask
endmodule

//--- verification/bimec_regs_monitor.sv
`timescale 1ns/1ps
// port-level checks of the mode and error register bank
module bimec_regs_monitor (
  input wire logic i_clk_sys, // clock
  input wire logic i_reset_n, // reset, active low
  input wire logic [bimec_pkg::ADDR_W-1:0] i_reg_addr, // address
  input wire logic i_reg_rd, // read strobe
  input wire logic [31:0] o_reg_rdata, // read data
  input wire logic i_crd, // correctable read
  input wire logic o_lockout_drive, // lockout drive
  input wire logic i_own_req, // own request
  input wire logic i_own_wb_kind, // victim or secondary write
  input wire logic o_own_grant_ok, // grant
  input wire logic i_arb_drop, // arbitration drop
  input wire logic [3:0] i_pmap_pe, // primary-map parity
  input wire logic o_node_err_sum, // error summary
  input wire logic o_irq // interrupt
);
  import bimec_pkg::*;
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_reset_n);
  // read of the error flags
  sequence s_rd_merr;
    i_reg_rd && i_reg_addr == OFF_MERR;
  endsequence
  // the read data that follow such a read
  sequence s_flags_seen;
    s_rd_merr ##1 o_reg_rdata[10:0] != 11'h000;
  endsequence
  a_drop_summary: assert property (i_arb_drop |-> ##[1:2] o_node_err_sum) else $error("drop not summarised");
  a_pmap_visible: assert property (i_pmap_pe != 4'h0 ##[1:2] s_rd_merr |=> o_reg_rdata[3:0] != 4'h0) else $error("pmap lost");
  a_rsvd_zero: assert property (s_rd_merr |=> o_reg_rdata[31:11] == 21'h0) else $error("reserved bits set");
  a_rdata_idle: assert property (!i_reg_rd |=> o_reg_rdata == 32'h0) else $error("read data without read");
  a_irq_summary: assert property (o_irq |-> o_node_err_sum) else $error("irq without summary");
  a_flags_summary: assert property (s_flags_seen |-> ##[0:1] o_node_err_sum) else $error("summary missing");
  a_victim_passes: assert property (i_own_req && i_own_wb_kind |=> o_own_grant_ok) else $error("victim held");
  a_no_req_grant: assert property (!i_own_req |=> !o_own_grant_ok) else $error("grant without request");
  a_lockout_quiet: assert property (!i_crd [*4] |-> !o_lockout_drive) else $error("lockout without crd");
endmodule
bind bimec_regs bimec_regs_monitor u_mon (.i_clk_sys, .i_reset_n, .i_reg_addr, .i_reg_rd, .o_reg_rdata, .i_crd,
  .o_lockout_drive, .i_own_req, .i_own_wb_kind, .o_own_grant_ok, .i_arb_drop, .i_pmap_pe, .o_node_err_sum, .o_irq);

//--- verification/bimec_regs_test.sv
`timescale 1ns/1ps
module bimec_regs_test;
  import bimec_pkg::*;
  logic i_clk_sys = 1'b0, i_reset_n = 1'b0, i_reg_wr = 1'b0, i_reg_rd = 1'b0;
  logic i_own_req = 1'b0, i_own_wb_kind = 1'b0, i_snoop_write = 1'b0, i_pmap_hit = 1'b0;
  logic [11:0] i_reg_addr = 12'h000;
  logic [31:0] i_reg_wdata = 32'h0, o_reg_rdata;
  logic o_lockout_drive, o_own_grant_ok, o_snoop_inval, o_snoop_update, o_node_err_sum, o_irq, miss, lk, crd;
  logic [1:0] o_cache_size, o_pcache_org;
  logic [10:0] ev;
  logic [3:0] cmd;
  logic [33:0] adr;
  logic [7:0] syn;
  int n_fail = 0, n_checks = 0, cyc = 0;
  bimec_regs u_dut (.i_clk_sys, .i_reset_n, .i_reg_addr, .i_reg_wdata, .i_reg_wr, .i_reg_rd, .o_reg_rdata,
    .i_lockout_pin(lk), .o_lockout_drive, .i_own_req, .i_own_wb_kind, .o_own_grant_ok, .i_snoop_write, .i_pmap_hit,
    .o_snoop_inval, .o_snoop_update, .o_cache_size, .o_pcache_org, .i_crd(crd), .i_arb_drop(ev[10]),
    .i_arb_col(ev[9]), .i_data_dbe(ev[8]), .i_data_sbe(ev[7]), .i_map_pe(ev[6]), .i_stat_pe(ev[5]),
    .i_tag_pe(ev[4]), .i_probe_miss(miss), .i_pmap_pe(ev[3:0]), .i_err_cmd(cmd), .i_err_addr(adr),
    .i_err_syn(syn), .o_node_err_sum, .o_irq);
  bimec_node_model u_node (.i_clk_sys, .o_evt(ev), .o_miss(miss), .o_cmd(cmd), .o_addr(adr), .o_syn(syn),
    .o_lockout(lk), .o_crd(crd));
  // clock and hang guard
  always #2 i_clk_sys = ~i_clk_sys;
  always @(posedge i_clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_fail++;
      final_report();
    end
  end
  task automatic final_report;
    if (n_fail == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge i_clk_sys);
    i_reg_addr <= a;
    i_reg_wdata <= d;
    i_reg_wr <= 1'b1;
    @(posedge i_clk_sys);
    i_reg_wr <= 1'b0;
  endtask
  // read data are looked at in the cycle after the strobe
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    @(posedge i_clk_sys);
    i_reg_addr <= a;
    i_reg_rd <= 1'b1;
    @(posedge i_clk_sys);
    i_reg_rd <= 1'b0;
    @(negedge i_clk_sys);
    chk("rdata", e, o_reg_rdata);
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge i_clk_sys);
    @(negedge i_clk_sys);
  endtask
  initial begin
    repeat (4) @(posedge i_clk_sys);
    i_reset_n <= 1'b1;
    rd(OFF_MERR, 32'h0);
    rd(OFF_MODE, MODE_RESET);
    rd(12'hFFC, 32'h0);
    for (int k = 0; k < 4; k++) begin
      for (int h = 0; h < 2; h++) begin
        wr(OFF_MODE, 32'h10 | 32'(k * 5));
        @(posedge i_clk_sys);
        i_snoop_write <= 1'b1;
        i_pmap_hit <= h[0];
        wt(3);
        chk("size", 32'(k), 32'(o_cache_size));
        chk("inval", 32'(k == 1 || (k == 0 && h == 0)), 32'(o_snoop_inval));
        chk("update", 32'(k == 2 || (k == 0 && h == 1)), 32'(o_snoop_update));
      end
      rd(OFF_MODE, 32'h10 | 32'(k * 5));
    end
    chk("org", 32'h1, 32'(o_pcache_org));
    for (int i = 0; i < 11; i++) begin
      u_node.fire(i, 1'b0);
      rd(OFF_MERR, 32'h1 << i);
      chk("summary", 32'h1, 32'(o_node_err_sum));
      chk("irq", 32'h0, 32'(o_irq));
      if (i != 9) rd(OFF_CMD_LATCH, 32'h100 + 32'(i));
      if (i == 7 || i == 8) rd(OFF_SYN_LATCH, 32'(i));
      wr(OFF_MERR, 32'h0);
      rd(OFF_MERR, 32'h1 << i);
      wr(OFF_MERR, 32'h1 << i);
      rd(OFF_MERR, 32'h0);
      chk("summary", 32'h0, 32'(o_node_err_sum));
    end
    u_node.fire(5, 1'b1);
    rd(OFF_FILL_ADDR, 32'h105);
    rd(OFF_IF_STATUS, 32'h1);
    rd(OFF_CMD_LATCH, 32'h10A);
    wr(OFF_IRQ_MASK, 32'h20);
    wt(1);
    chk("irq", 32'h1, 32'(o_irq));
    wr(OFF_MERR, 32'h20);
    wt(1);
    chk("irq", 32'h0, 32'(o_irq));
    wr(OFF_MODE, 32'h4050);
    @(posedge i_clk_sys);
    i_own_req <= 1'b1;
    u_node.lock(1'b1, 1'b1);
    wt(4);
    chk("grant", 32'h0, 32'(o_own_grant_ok));
    chk("lockout", 32'h1, 32'(o_lockout_drive));
    @(posedge i_clk_sys);
    i_own_wb_kind <= 1'b1;
    wt(1);
    chk("grant", 32'h1, 32'(o_own_grant_ok));
    u_node.lock(1'b0, 1'b0);
    i_own_wb_kind <= 1'b0;
    wt(4);
    chk("grant", 32'h1, 32'(o_own_grant_ok));
    chk("lockout", 32'h0, 32'(o_lockout_drive));
    final_report();
  end
endmodule
